/* rtl/updown_counter_defs.vh */
// Purpose: Shared constants for the presettable up/down counter
// Assumes: 32-bit Avalon-MM word registers at byte addresses
// Notes: Included by bare name; definitions only
`ifndef UPDOWN_COUNTER_DEFS_VH
`define UPDOWN_COUNTER_DEFS_VH

// Register byte offsets
`define REG_CTRL 4'h0
`define REG_JAM 4'h4
`define REG_STATUS 4'h8
`define REG_EVENTS 4'hc

// Address width of the register window
`define ADDR_W 4

// Control register fields
`define CTRL_BINARY 0
`define CTRL_UP 1
`define CTRL_PRESET 2
`define CTRL_STEP 3

// Status register fields
`define STAT_COUNT_LO 0
`define STAT_COUNT_HI 3
`define STAT_TC_N 4
`define STAT_CE_N 5
`define STAT_PRESET 6

// Event register fields
`define EV_WRAP 0
`define EV_TOTAL_LO 8

// Reset values
`define CTRL_RESET 4'h3
`define JAM_RESET 4'h0
`define COUNT_RESET 4'h0

// Count limits
`define BIN_MAX 4'hf
`define DEC_MAX 4'h9
`define COUNT_MIN 4'h0
`define COUNT_ONE 4'h1

`endif

/* rtl/count_step_logic.v */
// Purpose: Next count value and look-ahead limit detect for one stage
// Assumes: Purely combinational; the caller holds the count state
// Notes: Decade states above nine fold back into range on the next step
`timescale 1ns/1ps
`default_nettype none
`include "updown_counter_defs.vh"

module count_step_logic
(
    // Current state
    input wire [3:0] count,
    // Mode
    input wire binary_mode,
    input wire count_up,
    // Results
    output reg [3:0] stepped,
    output reg at_limit
);

    reg [3:0] max_count;

    always @*
    begin
        max_count = binary_mode ? `BIN_MAX : `DEC_MAX;
        stepped = count;
        at_limit = 1'b0;
        if (count_up)
        begin
            // Any illegal decade state restarts at zero
            if (count >= max_count)
                stepped = `COUNT_MIN;
            else
                stepped = count + `COUNT_ONE;
            // Look-ahead decode straight from the state, no ripple
            at_limit = (count == max_count);
        end
        else
        begin
            if (count == `COUNT_MIN)
                stepped = max_count;
            else if (count > max_count)
                stepped = max_count;
            else
                stepped = count - `COUNT_ONE;
            at_limit = (count == `COUNT_MIN);
        end
    end

endmodule // count_step_logic

`default_nettype wire

/* rtl/presettable_up_down_counter.v */
// Purpose: Four-bit presettable binary/decade up/down counter with
//          Avalon-MM register access
// Assumes: count_clock and count_enable_n are synchronous to clk
// Notes: Preset and terminal count settle one clk after their inputs,
//        since every output is taken from a flip-flop
`timescale 1ns/1ps
`default_nettype none
`include "updown_counter_defs.vh"

// Overview of operation
// - Four-bit count state on four outputs
// - Preset enable loads jam value without count edge
// - Preset with all jam low clears count
// - Step once per edge when enables low
// - Hold count when enable high; track jam value while preset high
// - Terminal count low at limit, else high
// - Terminal count low only while enable low
// - Binary select high counts binary
// - Binary select low counts decade BCD
// - Direction high counts up, low down
// - Look-ahead terminal count in both modes
module presettable_up_down_counter
#(
    parameter WRAP_W = 16
)
(
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Avalon-MM slave
    input wire [`ADDR_W-1:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output reg waitrequest,
    // Counting inputs
    input wire count_clock,
    input wire count_enable_n,
    // Counter outputs
    output reg [3:0] count_q,
    output reg terminal_count_n
);

    // Software state
    reg binary_mode;
    reg count_up;
    reg preset_load_enable;
    reg step_request;
    reg [3:0] jam_value;
    reg wrap_seen;
    reg [WRAP_W-1:0] wrap_total;

    // Pin history
    reg count_clock_prev;

    // Combinational helpers
    wire [3:0] stepped;
    wire at_limit;
    wire [3:0] next_stepped;
    wire next_at_limit;
    reg [3:0] next_count;
    reg next_terminal_count_n;
    reg advance;
    reg wrap_event;
    wire request;
    wire accept;
    wire do_write;
    wire do_read;
    wire low_lane;
    reg [31:0] next_readdata;

    // Bus qualifiers
    assign request = read | write;
    assign accept = request & ~waitrequest;
    assign do_write = write & ~waitrequest;
    assign do_read = read & waitrequest;
    assign low_lane = byteenable[0];

    function is_reg;
        input [`ADDR_W-1:0] addr;
        input [`ADDR_W-1:0] offset;
        begin
            is_reg = (addr == offset);
        end
    endfunction

    // Step logic for the present state
    count_step_logic u_step
    (
        .count(count_q),
        .binary_mode(binary_mode),
        .count_up(count_up),
        .stepped(stepped),
        .at_limit(at_limit)
    );

    // Look-ahead on the state about to be stored
    count_step_logic u_lookahead
    (
        .count(next_count),
        .binary_mode(binary_mode),
        .count_up(count_up),
        .stepped(next_stepped),
        .at_limit(next_at_limit)
    );

    // Advance decision: pin edge or software step
    always @*
    begin
        advance = 1'b0;
        if (((count_clock & ~count_clock_prev) | step_request)
            && !count_enable_n && !preset_load_enable)
            advance = 1'b1;
    end

    // Next count state
    always @*
    begin
        next_count = count_q;
        wrap_event = 1'b0;
        if (preset_load_enable)
        begin
            // Load wins over any edge; zero jam is the only clear
            next_count = jam_value;
        end
        else if (advance)
        begin
            next_count = stepped;
            wrap_event = at_limit;
        end
        else
        begin
            next_count = count_q;
        end
    end

    // Terminal count is decoded from the state about to be stored and registered with it
    always @*
    begin
        next_terminal_count_n = 1'b1;
        if (!count_enable_n && next_at_limit)
            next_terminal_count_n = 1'b0;
    end

    // Count state and its outputs
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count_q <= `COUNT_RESET;
            terminal_count_n <= 1'b1;
            count_clock_prev <= 1'b0;
        end
        else
        begin
            count_q <= next_count;
            terminal_count_n <= next_terminal_count_n;
            count_clock_prev <= count_clock;
        end
    end

    // Bus handshake: one wait state, then the access completes
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            waitrequest <= 1'b1;
        end
        else
        begin
            if (request && waitrequest)
                waitrequest <= 1'b0;
            else
                waitrequest <= 1'b1;
        end
    end

    // Read mux, captured during the wait state
    always @*
    begin
        next_readdata = 32'h0000_0000;
        if (is_reg(address, `REG_CTRL))
        begin
            next_readdata[`CTRL_BINARY] = binary_mode;
            next_readdata[`CTRL_UP] = count_up;
            next_readdata[`CTRL_PRESET] = preset_load_enable;
        end
        else if (is_reg(address, `REG_JAM))
        begin
            next_readdata[3:0] = jam_value;
        end
        else if (is_reg(address, `REG_STATUS))
        begin
            next_readdata[`STAT_COUNT_HI:`STAT_COUNT_LO] = count_q;
            next_readdata[`STAT_TC_N] = terminal_count_n;
            next_readdata[`STAT_CE_N] = count_enable_n;
            next_readdata[`STAT_PRESET] = preset_load_enable;
        end
        else if (is_reg(address, `REG_EVENTS))
        begin
            next_readdata[`EV_WRAP] = wrap_seen;
            next_readdata[`EV_TOTAL_LO +: WRAP_W] = wrap_total;
        end
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            readdata <= 32'h0000_0000;
        else if (do_read)
            readdata <= next_readdata;
        else if (!request)
            readdata <= 32'h0000_0000;
    end

    // Control and jam registers
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            binary_mode <= ((`CTRL_RESET >> `CTRL_BINARY) & 4'h1) != 4'h0;
            count_up <= 1'b1;
            preset_load_enable <= 1'b0;
            jam_value <= `JAM_RESET;
        end
        else if (do_write && low_lane)
        begin
            if (is_reg(address, `REG_CTRL))
            begin
                binary_mode <= writedata[`CTRL_BINARY];
                count_up <= writedata[`CTRL_UP];
                preset_load_enable <= writedata[`CTRL_PRESET];
            end
            else if (is_reg(address, `REG_JAM))
            begin
                jam_value <= writedata[3:0];
            end
        end
    end

    // Software step is a one-cycle pulse; it acts like a count edge
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            step_request <= 1'b0;
        else
            step_request <= do_write && low_lane && is_reg(address, `REG_CTRL)
                && writedata[`CTRL_STEP];
    end

    // Wrap events: sticky flag cleared by writing one, set beats clear
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrap_seen <= 1'b0;
            wrap_total <= {WRAP_W{1'b0}};
        end
        else
        begin
            if (wrap_event)
                wrap_seen <= 1'b1;
            else if (do_write && low_lane && is_reg(address, `REG_EVENTS)
                && writedata[`EV_WRAP])
                wrap_seen <= 1'b0;
            // The total simply rolls over; it is a diagnostic only
            if (wrap_event)
                wrap_total <= wrap_total + {{(WRAP_W-1){1'b0}}, 1'b1};
        end
    end

endmodule // presettable_up_down_counter

`default_nettype wire

/* dv/count_source.sv */
// Purpose: Far-side control logic making the counting clock
// Assumes: Shares clk with the counter
// Notes: Gives one-cycle high pulses on request
`timescale 1ns/1ps
`default_nettype none
module count_source
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Request
    input wire logic go,
    // Counting clock
    output logic count_clock
);
// Low for at least one edge between rises, so no rise is ever merged
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
        count_clock <= 1'b0;
    else
        // Shared clk cascading chosen for synchronous response
        count_clock <= go && !count_clock;
end
endmodule // count_source
`default_nettype wire

/* dv/counter_props.sv */
// Purpose: Port checks for the presettable counter
// Assumes: One clock domain
// Notes: Mode bits are shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "updown_counter_defs.vh"
module counter_props
#(
    parameter WRAP_W = 16
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register bus
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Counting
    input wire logic count_clock,
    input wire logic count_enable_n,
    input wire logic [3:0] count_q,
    input wire logic terminal_count_n
);
logic bin_s, up_s, pre_s, wr_done;
logic [3:0] jam_s, lim, next_cnt;
assign wr_done = write && !waitrequest && byteenable[0];
assign lim = bin_s ? 4'hf : 4'h9;
assign next_cnt = up_s ? ((count_q >= lim) ? 4'h0 : count_q + 4'h1)
    : ((count_q == 4'h0 || count_q > lim) ? lim : count_q - 4'h1);
// Shadow lets a step be predicted from the ports alone
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
        {jam_s, pre_s, up_s, bin_s} <= 7'h03;
    else if (wr_done && address == `REG_CTRL)
        {pre_s, up_s, bin_s} <= writedata[2:0];
    else if (wr_done && address == `REG_JAM)
        jam_s <= writedata[3:0];
end
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
sequence s_req;
    (read || write) && waitrequest;
endsequence
sequence s_rise;
    count_clock && !$past(count_clock) && !count_enable_n;
endsequence
a_one_wait: assert property (s_req |=> !waitrequest) else $error("no answer after one wait");
a_wait_pulse: assert property (!waitrequest |=> waitrequest) else $error("wait low too long");
a_idle_ready: assert property (!read && !write |-> waitrequest) else $error("wait low while idle");
a_tc_disabled: assert property (count_enable_n |=> terminal_count_n)
    else $error("carry low while disabled");
a_tc_exact: assert property (!$past(wr_done) && count_q <= lim |-> terminal_count_n ==
    !($past(!count_enable_n) && (up_s ? count_q == lim : count_q == 4'h0))) else $error("carry wrong");
a_advance_step: assert property (s_rise ##0 (!pre_s && !$past(wr_done))
    |=> count_q == $past(next_cnt)) else $error("bad count step");
a_hold_still: assert property ((count_enable_n || !count_clock || $past(count_clock))
    && !$past(wr_done) |=> $stable(count_q)) else $error("count moved without edge");
a_preset_load: assert property (pre_s && $past(pre_s) && !$past(wr_done) |-> count_q == jam_s)
    else $error("preset not loaded");
endmodule // counter_props
bind presettable_up_down_counter counter_props #(.WRAP_W(WRAP_W)) i_counter_props (.clk(clk), .nrst(nrst),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .count_clock(count_clock),
    .count_enable_n(count_enable_n), .count_q(count_q), .terminal_count_n(terminal_count_n));
`default_nettype wire

/* dv/presettable_up_down_counter_bench.sv */
// Purpose: Self-checking bench for the presettable counter
// Assumes: Registers reached over Avalon-MM
// Notes: Wrap total width shortened to 4
`timescale 1ns/1ps
`default_nettype none
`include "updown_counter_defs.vh"
module presettable_up_down_counter_bench;
logic clk, nrst, read, write, waitrequest, count_clock, count_enable_n, terminal_count_n, go;
logic [3:0] address, byteenable, count_q;
logic [31:0] writedata, readdata, rd;
int fail_count, cmp_count;
presettable_up_down_counter #(.WRAP_W(4)) i_presettable_up_down_counter (.clk(clk), .nrst(nrst),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .count_clock(count_clock),
    .count_enable_n(count_enable_n), .count_q(count_q), .terminal_count_n(terminal_count_n));
count_source i_count_source (.clk(clk), .nrst(nrst), .go(go), .count_clock(count_clock));
initial
begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
end
task chk(input logic [31:0] seen, input logic [31:0] exp);
begin
    cmp_count++;
    if (seen !== exp)
    begin
        fail_count++;
        $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
end
endtask
// Waits on waitrequest with a bound rather than a fixed latency
task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
int n;
begin
    n = 0;
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
        @(posedge clk);
        n++;
    end
    if (n >= 20)
    begin
        fail_count++;
        end_sim;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
end
endtask
task pulse;
begin
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
end
endtask
task t_reset;
begin
    bus(0, `REG_CTRL, 0);
    chk(rd, 32'h3);
    bus(0, `REG_STATUS, 0);
    chk(rd & 32'h7f, 32'h10);
    bus(0, 4'h2, 0);
    chk(rd, 32'h0);
    $display("reset test done");
end
endtask
task t_preset;
begin
    bus(1, `REG_JAM, 32'h5);
    bus(1, `REG_CTRL, 32'h7);
    pulse;
    chk(count_q, 32'h5);
    byteenable <= 4'h0;
    bus(1, `REG_JAM, 32'h9);
    byteenable <= 4'hf;
    bus(0, `REG_JAM, 0);
    chk(rd, 32'h5);
    bus(1, `REG_JAM, 32'h0);
    repeat (2) @(posedge clk);
    chk(count_q, 32'h0);
    $display("preset test done");
end
endtask
task t_bin_up;
begin
    bus(1, `REG_JAM, 32'he);
    bus(1, `REG_CTRL, 32'h3);
    chk(count_q, 32'he);
    pulse;
    chk(count_q, 32'hf);
    chk(terminal_count_n, 32'h0);
    pulse;
    chk(count_q, 32'h0);
    chk(terminal_count_n, 32'h1);
    bus(0, `REG_EVENTS, 0);
    chk(rd, 32'h101);
    bus(1, `REG_EVENTS, 32'h1);
    bus(0, `REG_EVENTS, 0);
    chk(rd, 32'h100);
    $display("binary test done");
end
endtask
task t_dec_down;
begin
    bus(1, `REG_JAM, 32'h1);
    bus(1, `REG_CTRL, 32'h4);
    bus(1, `REG_CTRL, 32'h0);
    pulse;
    chk(count_q, 32'h0);
    chk(terminal_count_n, 32'h0);
    count_enable_n <= 1'b1;
    pulse;
    chk(count_q, 32'h0);
    chk(terminal_count_n, 32'h1);
    count_enable_n <= 1'b0;
    bus(1, `REG_CTRL, 32'h8);
    repeat (2) @(posedge clk);
    chk(count_q, 32'h9);
    pulse;
    chk(count_q, 32'h8);
    $display("decade test done");
end
endtask
task end_sim;
begin
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
end
endtask
initial
begin
    #20000;
    fail_count++;
    end_sim;
end
initial
begin
    {nrst, read, write, go, count_enable_n} = 5'h0;
    address = 4'h0;
    byteenable = 4'hf;
    writedata = 32'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_preset;
    t_bin_up;
    t_dec_down;
    end_sim;
end
endmodule // presettable_up_down_counter_bench
`default_nettype wire
